/* File: logic/dcc_top.sv */
// dcc_top: control, result latch and readback for two analog comparators
// What this block does
// R1 - each comparator runs only while its enable bit is set and is powered down when it is clear.
// R2 - a two-bit field per comparator picks one of four analog pins for the inverting input.
// R3 - a bit per comparator picks the internal reference or an analog pin for the non-inverting input.
// R4 - each result is readable in its own control register and mirrored in the auxiliary register.
// R5 - the result reaches its pin only with output enable set, direction output and comparator on.
// R6 - output enable replaces the port latch on the pin; the comparator enable does not affect this.
// R7 - the internal result is captured once per cycle and the pin path adds one more latch before the pin.
// R8 - with invert clear the result is one when inverting is below non-inverting, else inverted.
// R9 - comparator two has an auxiliary register for timer gating and reading both results at once.
// R10 - software waits out response and reference settling time after changing an input.
// R11 - software sets analog select and direction bits before using comparator pins as inputs.
// R12 - a gate-source bit in the auxiliary register picks the gate pin or comparator two for the timer.
// R13 - the analog result is synchronised on the clock before the per-cycle latch.
`timescale 1ns/100ps
module dcc_top
  import dcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [dcc_pkg::DCC_ADDR_W-1:0] reg_addr_i,
  input wire logic [dcc_pkg::DCC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [dcc_pkg::DCC_DATA_W-1:0] reg_rdata_o,
  input wire logic [dcc_pkg::DCC_NUM_CMP-1:0] raw_compare_i,
  input wire logic timer_gate_pin_i,
  input wire logic [dcc_pkg::DCC_NUM_CMP-1:0] port_latch_i,
  input wire logic [dcc_pkg::DCC_NUM_CMP-1:0] pin_direction_bits_i,
  output logic [dcc_pkg::DCC_NUM_CMP-1:0] comparator_enable_o,
  output logic [2*dcc_pkg::DCC_NUM_CMP-1:0] inverting_input_select_o,
  output logic [dcc_pkg::DCC_NUM_CMP-1:0] reference_source_select_o,
  output logic [dcc_pkg::DCC_NUM_CMP-1:0] comparator_result_o,
  output logic [dcc_pkg::DCC_NUM_CMP-1:0] comparator_pin_o,
  output logic [dcc_pkg::DCC_NUM_CMP-1:0] comparator_pin_oe_n_o,
  output logic timer_gate_o
);

  import dcc_pkg::*;

  dcc_byte_t ctrl_one_ff;
  dcc_byte_t nxt_ctrl_one;
  dcc_byte_t ctrl_two_ff;
  dcc_byte_t nxt_ctrl_two;
  dcc_byte_t aux_ff;
  dcc_byte_t nxt_aux;
  dcc_byte_t rdata_ff;
  dcc_byte_t nxt_rdata;
  logic [DCC_NUM_CMP-1:0] result_ff;
  logic [DCC_NUM_CMP-1:0] nxt_result;
  logic gate_ff;
  logic nxt_gate;
  logic [DCC_NUM_CMP:0] sync_q;
  logic [DCC_NUM_CMP-1:0] en_bits;
  logic [DCC_NUM_CMP-1:0] inv_bits;
  logic [DCC_NUM_CMP-1:0] oe_bits;

  // raw comparator decisions and the timer gate pin are asynchronous
  dcc_sync #(
    .WIDTH(DCC_NUM_CMP + 1)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .async_i({timer_gate_pin_i, raw_compare_i}), // [R13]
    .sync_o(sync_q)
  );

  assign en_bits = {ctrl_two_ff[DCC_BIT_ENABLE], ctrl_one_ff[DCC_BIT_ENABLE]};
  assign inv_bits = {ctrl_two_ff[DCC_BIT_INVERT], ctrl_one_ff[DCC_BIT_INVERT]};
  assign oe_bits = {ctrl_two_ff[DCC_BIT_PIN_OE], ctrl_one_ff[DCC_BIT_PIN_OE]};

  // control registers; the result bit is not writable
  always_comb
  begin
    nxt_ctrl_one = ctrl_one_ff;
    nxt_ctrl_two = ctrl_two_ff;
    nxt_aux = aux_ff;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        DCC_ADDR_CMP_ONE:
        begin
          nxt_ctrl_one = reg_wdata_i & DCC_CTRL_WMASK; // [R2] [R3]
        end
        DCC_ADDR_CMP_TWO:
        begin
          nxt_ctrl_two = reg_wdata_i & DCC_CTRL_WMASK; // [R2] [R3]
        end
        DCC_ADDR_AUX:
        begin
          nxt_aux = reg_wdata_i & DCC_AUX_WMASK; // [R9] [R12]
        end
        default:
        begin
          nxt_aux = aux_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_one_ff <= DCC_CTRL_RESET;
      ctrl_two_ff <= DCC_CTRL_RESET;
      aux_ff <= DCC_AUX_RESET;
    end
    else if (ce_i)
    begin
      ctrl_one_ff <= nxt_ctrl_one;
      ctrl_two_ff <= nxt_ctrl_two;
      aux_ff <= nxt_aux;
    end
  end

  // per-cycle result latch; a powered-down comparator reads low
  always_comb
  begin
    nxt_result = '0;
    for (int k = 0; k < DCC_NUM_CMP; k++)
    begin
      if (en_bits[k]) // [R1]
      begin
        nxt_result[k] = sync_q[k] ^ inv_bits[k]; // [R8] [R7]
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      result_ff <= '0;
    end
    else if (ce_i)
    begin
      result_ff <= nxt_result;
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads give zero
  always_comb
  begin
    nxt_rdata = DCC_READ_IDLE;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        DCC_ADDR_CMP_ONE:
        begin
          nxt_rdata = ctrl_one_ff;
          nxt_rdata[DCC_BIT_RESULT] = result_ff[0]; // [R4]
        end
        DCC_ADDR_CMP_TWO:
        begin
          nxt_rdata = ctrl_two_ff;
          nxt_rdata[DCC_BIT_RESULT] = result_ff[1]; // [R4]
        end
        DCC_ADDR_AUX:
        begin
          // both results from one access, so software sees a coherent pair
          nxt_rdata = aux_ff;
          nxt_rdata[DCC_BIT_MIRROR_ONE] = result_ff[0]; // [R4] [R9]
          nxt_rdata[DCC_BIT_MIRROR_TWO] = result_ff[1]; // [R4] [R9]
        end
        default:
        begin
          nxt_rdata = DCC_READ_IDLE;
        end
      endcase
    end
  end

  // timer gate source; the gate pin arrives through the synchroniser
  always_comb
  begin
    nxt_gate = aux_ff[DCC_BIT_GATE_SEL] ? result_ff[1] : sync_q[DCC_NUM_CMP]; // [R12]
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_ff <= DCC_READ_IDLE;
      gate_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_ff <= nxt_rdata;
      gate_ff <= nxt_gate;
    end
  end

  dcc_pin_drive u_pin (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .result_i(result_ff),
    .pin_output_enable_i(oe_bits),
    .port_latch_i(port_latch_i),
    .pin_direction_bits_i(pin_direction_bits_i),
    .pin_o(comparator_pin_o),
    .pin_oe_n_o(comparator_pin_oe_n_o)
  );

  // analog controls straight from the control registers
  assign comparator_enable_o = en_bits; // [R1]
  assign inverting_input_select_o = {ctrl_two_ff[DCC_CH_W-1:0], ctrl_one_ff[DCC_CH_W-1:0]}; // [R2]
  assign reference_source_select_o = {ctrl_two_ff[DCC_BIT_REF_SEL],
                                      ctrl_one_ff[DCC_BIT_REF_SEL]}; // [R3]
  assign comparator_result_o = result_ff;
  assign reg_rdata_o = rdata_ff;
  assign timer_gate_o = gate_ff;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_off_low;
    ce_i && !en_bits[0] |=> !result_ff[0] && !comparator_result_o[0];
  endproperty
  a_off_low: assert property (p_off_low) else $error("disabled comparator result not low"); // [R1]

  property p_channel;
    ce_i && reg_wr_i && reg_addr_i == DCC_ADDR_CMP_TWO
      |=> inverting_input_select_o[3:2] == $past(reg_wdata_i[1:0]);
  endproperty
  a_channel: assert property (p_channel) else $error("channel select not taken"); // [R2]

  property p_refsel;
    ce_i && reg_wr_i && reg_addr_i == DCC_ADDR_CMP_ONE
      |=> reference_source_select_o[0] == $past(reg_wdata_i[DCC_BIT_REF_SEL]);
  endproperty
  a_refsel: assert property (p_refsel) else $error("reference select not taken"); // [R3]

  property p_mirror;
    ce_i && reg_rd_i && reg_addr_i == DCC_ADDR_AUX
      |=> reg_rdata_o[DCC_BIT_MIRROR_ONE] == $past(result_ff[0])
          && reg_rdata_o[DCC_BIT_MIRROR_TWO] == $past(result_ff[1]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror bits wrong"); // [R4]

  property p_pin_result;
    ce_i && oe_bits[0] && !pin_direction_bits_i[0] && en_bits[0]
      |=> comparator_pin_o[0] == $past(result_ff[0]) && !comparator_pin_oe_n_o[0];
  endproperty
  a_pin_result: assert property (p_pin_result) else $error("pin lacks result"); // [R5]

  property p_port_latch;
    ce_i && !oe_bits[1] |=> comparator_pin_o[1] == $past(port_latch_i[1]);
  endproperty
  a_port_latch: assert property (p_port_latch) else $error("port latch not passed"); // [R6]

  property p_polarity;
    ce_i && en_bits[1] |=> result_ff[1] == ($past(sync_q[1]) ^ $past(inv_bits[1]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong"); // [R8]

  property p_sync;
    (ce_i && raw_compare_i[0])[*4] |=> sync_q[0];
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser too slow"); // [R13]

  property p_hold;
    !ce_i |=> $stable(result_ff) && $stable(reg_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved without enable"); // [R7]

  property p_gate;
    ce_i && aux_ff[DCC_BIT_GATE_SEL] |=> timer_gate_o == $past(result_ff[1]);
  endproperty
  a_gate: assert property (p_gate) else $error("timer gate source wrong"); // [R12]

  property p_unmapped;
    ce_i && reg_rd_i && reg_addr_i == 2'h3 |=> reg_rdata_o == DCC_READ_IDLE;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [R9]

  c_aux_read: cover property (ce_i && reg_rd_i && reg_addr_i == DCC_ADDR_AUX ##1 reg_rdata_o[1:0] == 2'h3);
  c_pin_drive: cover property (ce_i && oe_bits[0] && en_bits[0] ##1 comparator_pin_o[0]);
  c_gate_cmp: cover property (aux_ff[DCC_BIT_GATE_SEL] && timer_gate_o);

  // a pin set as input has its driver switched off at the next enabled clock edge
  property p_dir_input;
    ce_i && pin_direction_bits_i[0] |=> comparator_pin_oe_n_o[0];
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("pin driven while input"); // [R5]

  c_override: cover property (ce_i && oe_bits[0] && !en_bits[0] && port_latch_i[0]
                              ##1 !comparator_pin_o[0]);

endmodule

/* File: logic/dcc_pkg.sv */
// dcc_pkg: constants shared by the dual comparator control block
package dcc_pkg;

  localparam int unsigned DCC_ADDR_W = 2;
  localparam int unsigned DCC_DATA_W = 8;
  localparam int unsigned DCC_NUM_CMP = 2;
  localparam int unsigned DCC_SYNC_STAGES = 3;

  // register indices on the register port
  localparam logic [1:0] DCC_ADDR_CMP_ONE = 2'h0;
  localparam logic [1:0] DCC_ADDR_CMP_TWO = 2'h1;
  localparam logic [1:0] DCC_ADDR_AUX = 2'h2;

  // comparator control register fields
  localparam int unsigned DCC_BIT_ENABLE = 7;
  localparam int unsigned DCC_BIT_RESULT = 6;
  localparam int unsigned DCC_BIT_PIN_OE = 5;
  localparam int unsigned DCC_BIT_INVERT = 4;
  localparam int unsigned DCC_BIT_REF_SEL = 2;
  localparam int unsigned DCC_BIT_CH_LO = 0;
  localparam int unsigned DCC_CH_W = 2;

  // auxiliary control register fields
  localparam int unsigned DCC_BIT_MIRROR_ONE = 0;
  localparam int unsigned DCC_BIT_MIRROR_TWO = 1;
  localparam int unsigned DCC_BIT_GATE_SEL = 4;

  // values after reset and writable masks
  localparam logic [7:0] DCC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DCC_AUX_RESET = 8'h00;
  localparam logic [7:0] DCC_CTRL_WMASK = 8'hb7;
  localparam logic [7:0] DCC_AUX_WMASK = 8'h10;
  localparam logic [7:0] DCC_READ_IDLE = 8'h00;

  typedef logic [7:0] dcc_byte_t;

endpackage

/* File: logic/dcc_sync.sv */
// dcc_sync: three-stage synchroniser with agreement filter, one per bit
`timescale 1ns/100ps
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int unsigned WIDTH = 3
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic [DCC_SYNC_STAGES-1:0] stage_ff;
      logic [DCC_SYNC_STAGES-1:0] nxt_stage;
      logic value_ff;
      logic nxt_value;

      // first stage feeds only the second; accept once stages two and three agree
      always_comb
      begin
        nxt_stage = {stage_ff[DCC_SYNC_STAGES-2:0], async_i[g]};
        nxt_value = value_ff;
        if (stage_ff[1] == stage_ff[2])
        begin
          nxt_value = stage_ff[2];
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          stage_ff <= '0;
          value_ff <= 1'b0;
        end
        else if (ce_i)
        begin
          stage_ff <= nxt_stage;
          value_ff <= nxt_value;
        end
      end

      assign sync_o[g] = value_ff;
    end
  endgenerate

endmodule

/* File: logic/dcc_pin_drive.sv */
// dcc_pin_drive: port override and pin driver registers per comparator
`timescale 1ns/100ps
module dcc_pin_drive
  import dcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [DCC_NUM_CMP-1:0] result_i,
  input wire logic [DCC_NUM_CMP-1:0] pin_output_enable_i,
  input wire logic [DCC_NUM_CMP-1:0] port_latch_i,
  input wire logic [DCC_NUM_CMP-1:0] pin_direction_bits_i,
  output logic [DCC_NUM_CMP-1:0] pin_o,
  output logic [DCC_NUM_CMP-1:0] pin_oe_n_o
);

  genvar g;
  generate
    for (g = 0; g < DCC_NUM_CMP; g++)
    begin : g_pin
      logic data_ff;
      logic nxt_data;
      logic oe_n_ff;
      logic nxt_oe_n;

      // result is already forced low while the comparator is off, so the
      // override still applies then and shows a steady low
      always_comb
      begin
        nxt_data = pin_output_enable_i[g] ? result_i[g] : port_latch_i[g]; // [R6] [R5]
        nxt_oe_n = pin_direction_bits_i[g]; // [R5]
      end

      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          data_ff <= 1'b0;
          oe_n_ff <= 1'b1;
        end
        else if (ce_i)
        begin
          data_ff <= nxt_data;
          oe_n_ff <= nxt_oe_n;
        end
      end

      assign pin_o[g] = data_ff;
      assign pin_oe_n_o[g] = oe_n_ff;
    end
  endgenerate

endmodule

/* File: verification/dcc_analog_model.sv */
// dcc_analog_model: behavioural analog front end of both comparators
`timescale 1ns/100ps
module dcc_analog_model
  import dcc_pkg::*;
#(
  parameter int RESP_NS = 10
)
(
  input wire logic clk_i,
  input wire logic [DCC_NUM_CMP-1:0] enable_i,
  input wire logic [3:0] chan_sel_i,
  input wire logic [DCC_NUM_CMP-1:0] ref_sel_i,
  input wire logic [31:0] neg_lvl_i,
  input wire logic [15:0] pos_lvl_i,
  input wire logic [7:0] ref_lvl_i,
  output logic [DCC_NUM_CMP-1:0] raw_o
);
  logic [DCC_NUM_CMP-1:0] decide;
  logic junk_ff = 1'b0;

  // a powered-down comparator gives no steady answer, so toggle
  always @(posedge clk_i) junk_ff <= ~junk_ff;

  always_comb
  begin
    for (int c = 0; c < DCC_NUM_CMP; c++)
    begin
      decide[c] = neg_lvl_i[8*chan_sel_i[2*c +: 2] +: 8] <
        (ref_sel_i[c] ? ref_lvl_i : pos_lvl_i[8*c +: 8]);
      if (!enable_i[c])
        decide[c] = junk_ff ^ (c == 1);
    end
  end

  // slow analog answer, not aligned to the clock; transport delay per change,
  // so a toggling powered-down comparator cannot hold back the other answer
  always @(decide) raw_o <= #(RESP_NS) decide;
endmodule

/* File: verification/dcc_top_test.sv */
// dcc_top_test: directed bench for the dual comparator control block
`timescale 1ns/100ps
`define CHK(A, B) begin cmp_count++; if ((A) !== (B)) begin err_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, (A), (B)); end end
module dcc_top_test;
  import dcc_pkg::*;
  // inverting pin levels ch3..ch0, non-inverting pins, internal reference
  localparam logic [31:0] NEG = {8'h96, 8'h5a, 8'hc8, 8'h0a};
  localparam logic [15:0] POS = {8'h78, 8'h64};
  localparam logic [7:0] REF = 8'ha0;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [1:0] addr = '0;
  dcc_byte_t wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic gate_pin = 1'b0;
  logic [1:0] port_latch = 2'b00;
  logic [1:0] dir = 2'b11;
  logic [1:0] raw;
  dcc_byte_t rdata;
  dcc_byte_t rv;
  logic [1:0] cmp_en;
  logic [3:0] chan_sel;
  logic [1:0] ref_sel;
  logic [1:0] result;
  logic [1:0] pin;
  logic [1:0] pin_oe_n;
  logic gate;
  int err_count = 0;
  int cmp_count = 0;

  initial forever #2 clk = ~clk;

  dcc_top u_dcc_top (
    .clk_i(clk),
    .reset_n_i(reset_n),
    .ce_i(ce),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata),
    .reg_wr_i(wr),
    .reg_rd_i(rd),
    .reg_rdata_o(rdata),
    .raw_compare_i(raw),
    .timer_gate_pin_i(gate_pin),
    .port_latch_i(port_latch),
    .pin_direction_bits_i(dir),
    .comparator_enable_o(cmp_en),
    .inverting_input_select_o(chan_sel),
    .reference_source_select_o(ref_sel),
    .comparator_result_o(result),
    .comparator_pin_o(pin),
    .comparator_pin_oe_n_o(pin_oe_n),
    .timer_gate_o(gate)
  );

  dcc_analog_model #(.RESP_NS(10)) u_dcc_analog_model (
    .clk_i(clk),
    .enable_i(cmp_en),
    .chan_sel_i(chan_sel),
    .ref_sel_i(ref_sel),
    .neg_lvl_i(NEG),
    .pos_lvl_i(POS),
    .ref_lvl_i(REF),
    .raw_o(raw)
  );

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic reg_wr(input logic [1:0] a, input dcc_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output dcc_byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // software waits out response and settling before trusting a result
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  function automatic logic exp_bit(input int c, input logic [1:0] ch, input logic rs,
                                   input logic pol);
    return (NEG[8*ch +: 8] < (rs ? REF : POS[8*c +: 8])) ^ pol;
  endfunction

  task automatic t_regs();
    `CHK(pin_oe_n, 2'b11)
    for (int a = 0; a < 4; a++)
    begin
      reg_rd(a[1:0], rv);
      `CHK(rv, 8'h00)
    end
    reg_wr(DCC_ADDR_CMP_ONE, 8'h7f);
    #1;
    `CHK(chan_sel[1:0], 2'h3)
    `CHK(ref_sel[0], 1'b1)
    `CHK(cmp_en[0], 1'b0)
    reg_rd(DCC_ADDR_CMP_ONE, rv);
    `CHK(rv, 8'h37)
    reg_wr(DCC_ADDR_AUX, 8'hff);
    reg_rd(DCC_ADDR_AUX, rv);
    `CHK(rv, 8'h10)
    reg_wr(2'h3, 8'hff);
    reg_rd(2'h3, rv);
    `CHK(rv, 8'h00)
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(DCC_ADDR_CMP_TWO, 8'h13);
    ce <= 1'b1;
    reg_rd(DCC_ADDR_CMP_TWO, rv);
    `CHK(rv, 8'h00)
    reg_wr(DCC_ADDR_AUX, 8'h00);
  endtask

  // every channel, reference source and polarity on both comparators
  task automatic t_compare();
    logic [1:0] ch;
    logic [1:0] e;
    for (int k = 0; k < 16; k++)
    begin
      ch = k[1:0];
      reg_wr(DCC_ADDR_CMP_ONE, {1'b1, 2'b00, k[3], 1'b0, k[2], ch});
      reg_wr(DCC_ADDR_CMP_TWO, {1'b1, 2'b00, k[3], 1'b0, k[2], ~ch});
      e = {exp_bit(1, ~ch, k[2], k[3]), exp_bit(0, ch, k[2], k[3])};
      settle();
      `CHK(chan_sel, {~ch, ch})
      `CHK(ref_sel, {2{k[2]}})
      `CHK(cmp_en, 2'b11)
      `CHK(result, e)
      reg_rd(DCC_ADDR_AUX, rv);
      `CHK(rv[1:0], e)
      reg_rd(DCC_ADDR_CMP_TWO, rv);
      `CHK(rv[6], e[1])
    end
  endtask

  task automatic t_pin();
    int n;
    @(posedge clk);
    port_latch <= 2'b00;
    dir <= 2'b10;
    reg_wr(DCC_ADDR_CMP_ONE, 8'ha0);
    settle();
    `CHK(pin_oe_n, 2'b10)
    `CHK(pin[0], 1'b1)
    reg_wr(DCC_ADDR_CMP_ONE, 8'hb0);
    n = 0;
    while (result[0] !== 1'b0 && n < 12)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 12)
    begin
      err_count++;
      $display("FAIL t=%0t result never fell", $time);
      stop_test();
    end
    `CHK(pin[0], 1'b1)
    @(posedge clk);
    #1;
    `CHK(pin[0], 1'b0)
    reg_wr(DCC_ADDR_CMP_ONE, 8'h80);
    settle();
    `CHK({result[0], pin[0]}, 2'b10)
    @(posedge clk);
    port_latch <= 2'b11;
    reg_wr(DCC_ADDR_CMP_ONE, 8'h20);
    settle();
    `CHK({cmp_en[0], result[0], pin[0]}, 3'b000)
    `CHK(pin[1], 1'b1)
    @(posedge clk);
    dir <= 2'b11;
    settle();
    `CHK(pin_oe_n, 2'b11)
  endtask

  task automatic t_gate();
    reg_wr(DCC_ADDR_AUX, 8'h00);
    gate_pin <= 1'b1;
    settle();
    `CHK(gate, 1'b1)
    reg_wr(DCC_ADDR_CMP_TWO, 8'h80);
    reg_wr(DCC_ADDR_AUX, 8'h10);
    gate_pin <= 1'b0;
    settle();
    `CHK(gate, 1'b1)
    reg_wr(DCC_ADDR_CMP_TWO, 8'h90);
    settle();
    `CHK(gate, 1'b0)
  endtask

  // comparator pins start as inputs so the drivers stay off
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_compare();
    t_pin();
    t_gate();
    stop_test();
  end
endmodule
